// *** utd_core.sv ***
`timescale 1ns/1ps
`include "utd_defs.svh"

module utd_core
  import utd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        exec_start,
  input  wire logic        fatal_error,
  output utd_pkt_type      pkt,
  output logic             pkt_valid,
  input  wire logic        pkt_ready,
  input  wire logic        uf_valid,
  input  wire utd_uf_type  uf
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]          aw_addr_reg;    // Held write address
  logic                aw_held_reg;    // Write address taken
  logic [31:0]         w_data_reg;     // Held write data
  logic [3:0]          w_strb_reg;     // Held byte enables
  logic                w_held_reg;     // Write data taken
  logic                bvalid_reg;     // Write response pending
  logic [1:0]          bresp_reg;      // Write response code
  logic                rvalid_reg;     // Read data pending
  logic [31:0]         rdata_reg;      // Read data
  logic [1:0]          rresp_reg;      // Read response code
  logic                wr_fire;        // Register write this cycle
  logic [31:0]         w0_reg;         // Descriptor word zero
  logic [31:0]         w1_reg;         // Descriptor word one
  logic [7:0]          mask_reg;       // Microframe activity mask
  logic [14:0]         rem_reg;        // Bytes still to move
  logic [14:0]         rem_next;       // Bytes left after a packet
  logic [1:0]          pk_left_reg;    // Packets left this execution
  utd_state_type       state_reg;      // Engine state
  utd_pkt_type         pkt_reg;        // Packet on offer
  logic                pkt_fire;       // Packet accepted by link
  logic                done_clear;     // Hardware disarm request
  logic [95:0]         cnt_flat;       // Counts packed into words 5..7
  logic [23:0]         stat_flat;      // Status fields of word four
  logic [31:0]         w0_merged;      // Word zero as the held write would leave it
  logic [31:0]         w4_merged;      // Word four as the held write would leave it

  // Decoded views of word zero and word one; bits 2:1 of word zero are never looked at
  logic                armed;
  logic [1:0]          mult;
  logic [10:0]         mpl;
  logic [14:0]         tbt;
  logic [3:0]          endpoint_number;
  logic [6:0]          function_address;

  assign armed            = w0_reg[`UTD_ARMED_BIT];
  assign mult             = w0_reg[`UTD_MULT_HI:`UTD_MULT_LO];
  assign mpl              = w0_reg[`UTD_MPL_HI:`UTD_MPL_LO];
  assign tbt              = w0_reg[`UTD_TBT_HI:`UTD_TBT_LO];
  assign endpoint_number  = {w1_reg[`UTD_EPU_HI:`UTD_EPU_LO], w0_reg[`UTD_EP0_BIT]};
  assign function_address = w1_reg[`UTD_FA_HI:`UTD_FA_LO];

  // Byte-lane merge for software writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Packet size is the smaller of remaining bytes and the packet limit
  function automatic logic [10:0] pkt_size(input logic [14:0] rem, input logic [10:0] lim);
    logic [10:0] res;
    res = (rem < {4'h0, lim}) ? rem[10:0] : lim;
    return res;
  endfunction

  // Merged words are named nets because a function result cannot be part-selected
  assign w0_merged = merge(w0_reg, w_data_reg, w_strb_reg);
  assign w4_merged = merge({stat_flat, mask_reg}, w_data_reg, w_strb_reg);

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  // Address and data may arrive in either order; both are held until the write
  assign s_axi_awready = ce && !aw_held_reg;
  assign s_axi_wready  = ce && !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = ce && aw_held_reg && w_held_reg && !bvalid_reg;

  // Capture address and data, then answer one cycle after both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `UTD_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        // Only the software-owned words accept writes
        bvalid_reg  <= 1'b1;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        if (aw_addr_reg == `UTD_OFF_W0 || aw_addr_reg == `UTD_OFF_W1 ||
            aw_addr_reg == `UTD_OFF_ISO_W4) begin
          bresp_reg <= `UTD_RESP_OKAY;
        end else begin
          bresp_reg <= `UTD_RESP_SLVERR;
        end
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Descriptor words
  // ----------------------------------------
  // Hardware disarm is applied first so a software arm in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w0_reg <= `UTD_RST_WORD;
    end else if (ce) begin
      if (done_clear) begin
        w0_reg[`UTD_ARMED_BIT] <= 1'b0;
      end
      if (wr_fire && aw_addr_reg == `UTD_OFF_W0) begin
        w0_reg <= w0_merged & `UTD_W0_KEEP;
      end
    end
  end

  // Word one holds address and upper endpoint bits only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w1_reg <= `UTD_RST_WORD;
    end else if (ce && wr_fire && aw_addr_reg == `UTD_OFF_W1) begin
      w1_reg <= merge(w1_reg, w_data_reg, w_strb_reg) & `UTD_W1_KEEP;
    end
  end

  // ----------------------------------------
  // Execution engine
  // ----------------------------------------
  assign pkt_valid  = (state_reg == UTD_ISSUE);
  assign pkt        = pkt_reg;
  assign pkt_fire   = ce && pkt_valid && pkt_ready;
  assign rem_next   = rem_reg - {4'h0, pkt_reg.bytes};
  // Disarm on a fatal error, when the last payload byte has gone, or on a start with no bytes left
  assign done_clear = ce && (fatal_error ||
                      (pkt_fire && rem_next == 15'h0000) ||
                      (state_reg == UTD_IDLE && exec_start && armed && rem_reg == 15'h0000));

  // Remaining count reloads whenever software rewrites word zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_reg <= 15'h0000;
    end else if (ce) begin
      if (wr_fire && aw_addr_reg == `UTD_OFF_W0) begin
        rem_reg <= w0_merged[`UTD_TBT_HI:`UTD_TBT_LO];
      end else if (pkt_fire) begin
        rem_reg <= rem_next;
      end
    end
  end

  // One execution issues at most the multiplier's count of packets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= UTD_IDLE;
      pk_left_reg <= 2'h0;
      pkt_reg     <= '0;
    end else if (ce) begin
      case (state_reg)
        UTD_IDLE: begin
          if (exec_start && armed && rem_reg != 15'h0000 && !fatal_error) begin
            state_reg   <= UTD_ISSUE;
            // Undefined multiplier 00b is taken as a single packet
            pk_left_reg <= (mult == 2'h0) ? 2'h1 : mult;
            pkt_reg     <= '{function_address: function_address,
                             endpoint_number:  endpoint_number,
                             bytes:            pkt_size(rem_reg, mpl)};
          end
        end
        UTD_ISSUE: begin
          if (fatal_error) begin
            state_reg <= UTD_IDLE;
          end else if (pkt_fire) begin
            pk_left_reg   <= pk_left_reg - 2'h1;
            pkt_reg.bytes <= pkt_size(rem_next, mpl);
            if (rem_next == 15'h0000 || pk_left_reg == 2'h1) begin
              state_reg <= UTD_IDLE;
            end
          end
        end
        default: begin
          state_reg <= UTD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Isochronous status and received counts
  // ----------------------------------------
  // Activity mask is software-owned
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= 8'h00;
    end else if (ce && wr_fire && aw_addr_reg == `UTD_OFF_ISO_W4) begin
      mask_reg <= w4_merged[`UTD_MASK_W-1:0];
    end
  end

  // One status field and one count per microframe; a report only lands when its mask bit is set
  for (genvar k = 0; k < `UTD_UF_NUM; k++) begin : g_uf
    logic [2:0]  stat_reg;  // Microframe completion status
    logic [11:0] cnt_reg;   // Microframe received bytes
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stat_reg <= 3'h0;
        cnt_reg  <= 12'h000;
      end else if (ce) begin
        if (wr_fire && aw_addr_reg == `UTD_OFF_ISO_W4) begin
          stat_reg <= w4_merged[`UTD_STAT_BASE + k*`UTD_STAT_W +: `UTD_STAT_W];
        end
        // Hardware report overrides a software write in the same cycle
        if (uf_valid && uf.index == 3'(k) && mask_reg[k]) begin
          stat_reg <= uf.status;
          cnt_reg  <= uf.rx_count;
        end
      end
    end
    assign stat_flat[k*`UTD_STAT_W +: `UTD_STAT_W] = stat_reg;
    assign cnt_flat[k*`UTD_CNT_W +: `UTD_CNT_W]    = cnt_reg;
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Decode on address acceptance; unmapped reads answer SLVERR with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `UTD_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `UTD_RESP_OKAY;
        if (s_axi_araddr == `UTD_OFF_W0) begin
          rdata_reg <= w0_reg;
        end else if (s_axi_araddr == `UTD_OFF_W1) begin
          rdata_reg <= w1_reg;
        end else if (s_axi_araddr == `UTD_OFF_STATUS) begin
          rdata_reg <= {14'h0000, pk_left_reg, rem_reg, pkt_valid};
        end else if (s_axi_araddr == `UTD_OFF_ISO_W4) begin
          rdata_reg <= {stat_flat, mask_reg};
        end else if (s_axi_araddr == `UTD_OFF_ISO_W5) begin
          rdata_reg <= cnt_flat[31:0];
        end else if (s_axi_araddr == `UTD_OFF_ISO_W6) begin
          rdata_reg <= cnt_flat[63:32];
        end else if (s_axi_araddr == `UTD_OFF_ISO_W7) begin
          rdata_reg <= cnt_flat[95:64];
        end else begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `UTD_RESP_SLVERR;
        end
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule

// *** utd_defs.svh ***
`ifndef UTD_DEFS_SVH
`define UTD_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UTD_OFF_W0      8'h00
`define UTD_OFF_W1      8'h04
`define UTD_OFF_STATUS  8'h08
`define UTD_OFF_ISO_W4  8'h10
`define UTD_OFF_ISO_W5  8'h14
`define UTD_OFF_ISO_W6  8'h18
`define UTD_OFF_ISO_W7  8'h1C

// ----------------------------------------
// Bulk descriptor word zero fields
// ----------------------------------------
`define UTD_EP0_BIT     31
`define UTD_MULT_HI     30
`define UTD_MULT_LO     29
`define UTD_MPL_HI      28
`define UTD_MPL_LO      18
`define UTD_TBT_HI      17
`define UTD_TBT_LO      3
`define UTD_ARMED_BIT   0
`define UTD_W0_KEEP     32'hFFFFFFF9

// ----------------------------------------
// Descriptor word one fields
// ----------------------------------------
`define UTD_FA_HI       9
`define UTD_FA_LO       3
`define UTD_EPU_HI      2
`define UTD_EPU_LO      0
`define UTD_W1_KEEP     32'h000003FF

// ----------------------------------------
// Isochronous word four and count layout
// ----------------------------------------
`define UTD_MASK_W      8
`define UTD_STAT_W      3
`define UTD_STAT_BASE   8
`define UTD_CNT_W       12
`define UTD_UF_NUM      8

// ----------------------------------------
// Reset values and bus responses
// ----------------------------------------
`define UTD_RST_WORD    32'h00000000
`define UTD_RESP_OKAY   2'h0
`define UTD_RESP_SLVERR 2'h2

`endif

// *** utd_pkg.sv ***
package utd_pkg;

  // ----------------------------------------
  // Execution engine states
  // ----------------------------------------
  typedef enum logic [0:0] {
    UTD_IDLE  = 1'b0,
    UTD_ISSUE = 1'b1
  } utd_state_type;

  // ----------------------------------------
  // One data packet offered to the link side
  // ----------------------------------------
  typedef struct packed {
    logic [6:0]  function_address;  // Target function
    logic [3:0]  endpoint_number;   // Full endpoint number
    logic [10:0] bytes;             // Payload bytes in this packet
  } utd_pkt_type;

  // ----------------------------------------
  // One microframe completion report
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  index;             // Microframe 0..7
    logic [2:0]  status;            // Completion status code
    logic [11:0] rx_count;          // Bytes received
  } utd_uf_type;

endpackage

// *** utd_core_sva.sv ***
`timescale 1ns/1ps
module utd_core_sva
  import utd_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        exec_start,
  input wire logic        fatal_error,
  input wire utd_pkt_type pkt,
  input wire logic        pkt_valid,
  input wire logic        pkt_ready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // ----------------------------------------
  // Packets taken in this execution
  // ----------------------------------------
  logic [2:0] taken_reg;  // Three bits so a fourth packet shows
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  // Cleared when an idle engine is started
  always_ff @(posedge aclk) begin
    if (!aresetn) taken_reg <= 3'h0;
    else if (ce && exec_start && !pkt_valid) taken_reg <= 3'h0;
    else if (pkt_valid && pkt_ready && ce) taken_reg <= taken_reg + 3'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_pkt_cap; taken_reg <= 3'h3; endproperty
  property p_start; $rose(pkt_valid) |-> $past(exec_start); endproperty
  property p_hold; pkt_valid && !pkt_ready && !fatal_error |=> pkt_valid && $stable(pkt); endproperty
  property p_addr;
    pkt_valid ##1 pkt_valid |-> $stable(pkt.function_address) && $stable(pkt.endpoint_number);
  endproperty
  property p_bytes; pkt_valid |-> pkt.bytes <= 11'h200; endproperty
  property p_fatal; fatal_error |=> !pkt_valid; endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_bwait; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_pkt_cap: assert property (p_pkt_cap) else $error("too many packets in one execution");
  a_start: assert property (p_start) else $error("packet offered without a start");
  a_hold: assert property (p_hold) else $error("offered packet changed while stalled");
  a_addr: assert property (p_addr) else $error("target moved inside an execution");
  a_bytes: assert property (p_bytes) else $error("packet longer than bulk limit");
  a_fatal: assert property (p_fatal) else $error("fatal error did not abort");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_bwait: assert property (p_bwait) else $error("write answer dropped early");
  c_pkt: cover property (pkt_valid && pkt_ready);
  c_fatal: cover property (fatal_error && pkt_valid);
  c_three: cover property (taken_reg == 3'h3);
endmodule

bind utd_core utd_core_sva i_utd_core_sva (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .exec_start(exec_start), .fatal_error(fatal_error),
  .pkt(pkt), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready)
);

// *** utd_far_end.sv ***
`timescale 1ns/1ps
module utd_far_end
  import utd_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] mode,
  input  wire logic       pkt_valid,
  output logic            pkt_ready,
  output logic            uf_valid,
  output utd_uf_type      uf
);
  int seed = 92;  // Own stream so stalls do not shift bench values
  initial begin
    uf_valid = 1'b0;
    uf = '0;
  end
  // Ready: 0 prompt, 1 random stalls, 2 never
  always @(posedge aclk) begin
    if (!aresetn) pkt_ready <= 1'b0;
    else pkt_ready <= (mode == 2'h0) || (mode == 2'h1 && $random(seed) % 2 == 0);
  end
  // One-cycle microframe report; idle lines flip so stale data never looks valid
  task automatic send_uf(input logic [2:0] i, input logic [2:0] s, input logic [11:0] c);
    @(posedge aclk);
    uf <= '{index: i, status: s, rx_count: c};
    uf_valid <= 1'b1;
    @(posedge aclk);
    uf_valid <= 1'b0;
    uf <= utd_uf_type'(~uf);
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "utd_defs.svh"
module tb_top
  import utd_pkg::*;
;
  // ----------------------------------------
  // Signals and expectation queues
  // ----------------------------------------
  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, exec_start, fatal_error, pkt_valid, pkt_ready, uf_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mode;
  utd_pkt_type pkt;
  utd_uf_type  uf;
  logic [33:0] b_q[$], r_q[$], p_q[$];  // Oldest note first
  int          fail_count, cmp_count;
  int          seed = 92;

  utd_core i_utd_core (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .exec_start(exec_start),
    .fatal_error(fatal_error), .pkt(pkt), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .uf_valid(uf_valid), .uf(uf)
  );
  utd_far_end i_utd_far_end (
    .aclk(aclk), .aresetn(aresetn), .mode(mode), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .uf_valid(uf_valid), .uf(uf)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask
  // An empty queue gives X, which never matches
  function automatic logic [33:0] take(ref logic [33:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 34'hX;
  endfunction
  // Watches every completed transfer against the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) chk({32'h0, bresp}, take(b_q));
    if (rvalid && rready) chk({rresp, rdata}, take(r_q));
    if (pkt_valid && pkt_ready) chk(34'(pkt), take(p_q));
  end
  // ----------------------------------------
  // Bus and engine drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    b_q.push_back({32'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    r_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) hang();
  endtask
  // One start pulse, then wait until every noted packet went and the engine is idle
  task automatic run;
    int n;
    @(posedge aclk);
    exec_start <= 1'b1;
    @(posedge aclk);
    exec_start <= 1'b0;
    #1;
    for (n = 0; n < 3000 && (p_q.size() != 0 || pkt_valid); n++) begin
      @(posedge aclk);
      #1;
    end
    if (n == 3000) hang();
  endtask
  // Bulk descriptor run to completion; reserved bits 2:1 of word zero written as ones
  task automatic bulk(input logic [1:0] m, input logic [14:0] t, input logic [10:0] l);
    logic [3:0] ep;
    logic [6:0] fa;
    int         rem, k;
    ep = 4'($random(seed));
    fa = 7'($random(seed));
    rem = t;
    wr(`UTD_OFF_W1, {22'h0, fa, ep[3:1]}, `UTD_RESP_OKAY);
    wr(`UTD_OFF_W0, {ep[0], m, l, t, 2'h3, 1'b1}, `UTD_RESP_OKAY);
    while (rem > 0) begin
      for (k = 0; k < (m == 2'h0 ? 1 : m) && rem > 0; k++) begin
        p_q.push_back(34'({fa, ep, 11'(rem < l ? rem : l)}));
        rem -= (rem < l ? rem : l);
      end
      run();
    end
    rd(`UTD_OFF_W0, {2'h0, ep[0], m, l, t, 3'h0});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  offs[7];
    logic [7:0]  mask;
    logic [31:0] w4;
    logic [95:0] cnt;
    logic [2:0]  s;
    logic [11:0] c;
    offs = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, exec_start, fatal_error} = 7'h00;
    {awaddr, araddr, wdata, wstrb, mode} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], {`UTD_RESP_OKAY, `UTD_RST_WORD});
    rd(8'h0C, {`UTD_RESP_SLVERR, 32'h0});
    wr(8'h0C, 32'hFFFFFFFF, `UTD_RESP_SLVERR);
    wr(`UTD_OFF_STATUS, 32'hFFFFFFFF, `UTD_RESP_SLVERR);
    wr(`UTD_OFF_ISO_W5, 32'hFFFFFFFF, `UTD_RESP_SLVERR);
    wr(`UTD_OFF_W1, 32'hFFFFFFFF, `UTD_RESP_OKAY);
    rd(`UTD_OFF_W1, {`UTD_RESP_OKAY, 32'h000003FF});
    $display("Done: register map");
    // Every legal multiplier, prompt and stalling far end; 00b is never programmed
    for (int i = 0; i < 4; i++) begin
      mode <= 2'(i % 2);
      bulk(2'(1 + i % 3), 15'(1 + $unsigned($random(seed)) % 3000), 11'(1 + $unsigned($random(seed)) % 512));
    end
    bulk(2'h3, 15'h7FFF, 11'h200);
    $display("Done: bulk runs");
    // Abort while a packet is held, then a start on a disarmed descriptor
    mode <= 2'h2;
    wr(`UTD_OFF_W0, {1'b0, 2'h3, 11'h008, 15'h0064, 3'h1}, `UTD_RESP_OKAY);
    @(posedge aclk);
    exec_start <= 1'b1;
    @(posedge aclk);
    exec_start <= 1'b0;
    @(posedge aclk);
    fatal_error <= 1'b1;
    @(posedge aclk);
    fatal_error <= 1'b0;
    mode <= 2'h0;
    rd(`UTD_OFF_W0, {2'h0, 1'b0, 2'h3, 11'h008, 15'h0064, 3'h0});
    rd(`UTD_OFF_STATUS, {`UTD_RESP_OKAY, 14'h0000, 2'h3, 15'h0064, 1'b0});
    run();
    $display("Done: fatal abort");
    // Microframe reports, only masked slots land
    mask = 8'($random(seed));
    w4 = {24'h0, mask};
    cnt = '0;
    wr(`UTD_OFF_ISO_W4, w4, `UTD_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      s = 3'($random(seed));
      c = 12'($random(seed));
      i_utd_far_end.send_uf(3'(i), s, c);
      if (mask[i]) begin
        w4[8 + 3 * i +: 3] = s;
        cnt[12 * i +: 12] = c;
      end
    end
    rd(`UTD_OFF_ISO_W4, {`UTD_RESP_OKAY, w4});
    rd(`UTD_OFF_ISO_W5, {`UTD_RESP_OKAY, cnt[31:0]});
    rd(`UTD_OFF_ISO_W6, {`UTD_RESP_OKAY, cnt[63:32]});
    rd(`UTD_OFF_ISO_W7, {`UTD_RESP_OKAY, cnt[95:64]});
    $display("Done: microframe reports");
    stop_test();
  end
endmodule
